// ### rtl/serial_slave_control_port.v
// Serial control port: SPI or 2-wire slave with input status and mirror logic
`include "serial_slave_control_port_defines.vh"

module serial_slave_control_port (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire       interface_select,
  input  wire       cs_n_or_address_strap,
  input  wire       serial_clock_in,
  input  wire       mosi_or_input2,
  input  wire       local_input1,
  input  wire       local_input0,
  input  wire       serial_data_in,
  output reg        serial_data_out,
  output reg        serial_data_oe_n,
  output wire       two_wire_clock_out,
  output wire       two_wire_clock_oe_n,
  output reg  [6:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_write,
  input  wire [7:0] reg_rdata,
  output reg  [7:0] transmitter_mode_register,
  output reg  [2:0] remote_mirror_levels,
  input  wire       irq_request,
  output reg        irq
);

  localparam [2:0] I_IDLE = 3'h0;
  localparam [2:0] I_RX   = 3'h1;
  localparam [2:0] I_ACK  = 3'h2;
  localparam [2:0] I_TX   = 3'h3;
  localparam [2:0] I_MACK = 3'h4;
  localparam [2:0] I_WAIT = 3'h5;

  localparam [1:0] K_DEV  = 2'h0;
  localparam [1:0] K_REG  = 2'h1;
  localparam [1:0] K_DATA = 2'h2;

  wire [`PIN_COUNT-1:0] pins_raw;
  reg  [`PIN_COUNT-1:0] sync1;
  reg  [`PIN_COUNT-1:0] sync2;
  reg  [`PIN_COUNT-1:0] sync3;
  reg  [`PIN_COUNT-1:0] filt;
  reg  [`PIN_COUNT-1:0] filt_d;

  assign pins_raw = {serial_data_in, local_input0, local_input1, mosi_or_input2,
                     serial_clock_in, cs_n_or_address_strap, interface_select};

  // Three-stage synchroniser; a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g = g + 1) begin : pin_sync
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          sync1[g]  <= 1'b1;
          sync2[g]  <= 1'b1;
          sync3[g]  <= 1'b1;
          filt[g]   <= 1'b1;
          filt_d[g] <= 1'b1;
        end else begin
          sync1[g]  <= pins_raw[g];
          sync2[g]  <= sync1[g];
          sync3[g]  <= sync2[g];
          filt_d[g] <= filt[g];
          if (sync2[g] == sync3[g]) begin
            filt[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  wire two_wire_mode = filt[`PIN_SELECT];
  wire clk_rise      = filt[`PIN_CLOCK] & ~filt_d[`PIN_CLOCK];
  wire clk_fall      = ~filt[`PIN_CLOCK] & filt_d[`PIN_CLOCK];
  wire data_bit      = two_wire_mode ? filt[`PIN_DATA] : filt[`PIN_MOSI_OR_DD2];
  wire cs_active     = ~filt[`PIN_CS_OR_ADDR];
  wire tw_start      = filt[`PIN_CLOCK] & filt_d[`PIN_DATA] & ~filt[`PIN_DATA];
  wire tw_stop       = filt[`PIN_CLOCK] & ~filt_d[`PIN_DATA] & filt[`PIN_DATA];

  // The 2-wire clock pin is never stretched by this slave
  assign two_wire_clock_out  = 1'b0;
  assign two_wire_clock_oe_n = 1'b1;

  // Input levels; the shared pin carries serial input data in SPI mode
  wire [2:0] input_levels = {filt[`PIN_MOSI_OR_DD2] & two_wire_mode,
                             filt[`PIN_DD1], filt[`PIN_DD0]};

  // Read data: local registers answered here, the rest by the core
  reg [7:0] read_value;
  always @* begin
    if (reg_addr == `INPUT_STATUS_ADDR) begin
      read_value = {5'h00, input_levels};
    end else if (reg_addr == `MODE_REG_ADDR) begin
      read_value = transmitter_mode_register;
    end else begin
      read_value = reg_rdata;
    end
  end

  // Address strap is taken once, after the synchroniser settles out of reset
  reg [2:0] settle_cnt;
  reg       strap_taken;
  reg       address_strap;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt    <= 3'h0;
      strap_taken   <= 1'b0;
      address_strap <= 1'b0;
    end else if (!strap_taken) begin
      if (settle_cnt == `STRAP_SETTLE) begin
        address_strap <= filt[`PIN_CS_OR_ADDR];
        strap_taken   <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 3'h1;
      end
    end
  end

  reg [2:0] state;
  reg [1:0] kind;
  reg       rw;
  reg       first_byte;
  reg       spi_load;
  reg [2:0] bit_cnt;
  reg [7:0] rx_shift;
  reg [7:0] tx_shift;
  wire [7:0] rx_byte = {rx_shift[6:0], data_bit};

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state                     <= I_IDLE;
      kind                      <= K_DEV;
      rw                        <= 1'b0;
      first_byte                <= 1'b1;
      spi_load                  <= 1'b0;
      bit_cnt                   <= 3'h0;
      rx_shift                  <= 8'h00;
      tx_shift                  <= 8'h00;
      reg_addr                  <= 7'h00;
      reg_wdata                 <= 8'h00;
      reg_write                 <= 1'b0;
      transmitter_mode_register <= `MODE_REG_RESET;
      serial_data_out           <= 1'b1;
      serial_data_oe_n          <= 1'b1;
    end else begin
      reg_write <= 1'b0;
      if (!two_wire_mode) begin
        // SPI mode 0 slave
        state            <= I_IDLE;
        serial_data_oe_n <= ~cs_active;
        if (!cs_active) begin
          first_byte <= 1'b1;
          spi_load   <= 1'b0;
          bit_cnt    <= 3'h0;
        end else if (clk_rise) begin
          rx_shift <= rx_byte;
          bit_cnt  <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            first_byte <= 1'b0;
            if (first_byte) begin
              reg_addr <= rx_byte[6:0];
              rw       <= rx_byte[`CMD_READ_BIT];
              spi_load <= rx_byte[`CMD_READ_BIT];
            end else if (rw) begin
              spi_load <= 1'b1;
            end else begin
              reg_wdata <= rx_byte;
              reg_write <= 1'b1;
              reg_addr  <= reg_addr + 7'h01;
              if (reg_addr == `MODE_REG_ADDR) begin
                transmitter_mode_register <= rx_byte;
              end
            end
          end
        end else if (clk_fall) begin
          if (spi_load) begin
            serial_data_out <= read_value[7];
            tx_shift        <= {read_value[6:0], 1'b0};
            reg_addr        <= reg_addr + 7'h01;
            spi_load        <= 1'b0;
          end else begin
            serial_data_out <= tx_shift[7];
            tx_shift        <= {tx_shift[6:0], 1'b0};
          end
        end
      end else begin
        // 2-wire slave; bit timing follows the master's clock edges, start and stop follow data edges while clock is high
        first_byte <= 1'b1;
        spi_load   <= 1'b0;
        serial_data_out <= 1'b0;
        if (tw_start) begin
          state            <= I_RX;
          kind             <= K_DEV;
          bit_cnt          <= 3'h0;
          serial_data_oe_n <= 1'b1;
        end else if (tw_stop) begin
          state            <= I_IDLE;
          serial_data_oe_n <= 1'b1;
        end else begin
          case (state)
            I_RX: begin
              if (clk_rise) begin
                rx_shift <= rx_byte;
                bit_cnt  <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                  state <= I_ACK;
                  case (kind)
                    K_DEV: begin
                      if (rx_byte[7:1] == {address_strap, `DEV_ADDR_LOW}) begin
                        rw <= rx_byte[0];
                      end else begin
                        state <= I_WAIT;
                      end
                    end
                    K_REG: begin
                      reg_addr <= rx_byte[6:0];
                    end
                    default: begin
                      reg_wdata <= rx_byte;
                      reg_write <= 1'b1;
                      reg_addr  <= reg_addr + 7'h01;
                      if (reg_addr == `MODE_REG_ADDR) begin
                        transmitter_mode_register <= rx_byte;
                      end
                    end
                  endcase
                end
              end
            end
            I_ACK: begin
              // Acknowledge drives low from the fall after bit 8 to the next fall
              if (clk_fall) begin
                if (serial_data_oe_n) begin
                  serial_data_oe_n <= 1'b0;
                end else if (kind == K_DEV && rw) begin
                  state            <= I_TX;
                  bit_cnt          <= 3'h0;
                  serial_data_oe_n <= read_value[7] ? 1'b1 : 1'b0;
                  tx_shift         <= {read_value[6:0], 1'b0};
                  reg_addr         <= reg_addr + 7'h01;
                end else begin
                  state            <= I_RX;
                  kind             <= (kind == K_DEV) ? K_REG : K_DATA;
                  bit_cnt          <= 3'h0;
                  serial_data_oe_n <= 1'b1;
                end
              end
            end
            I_TX: begin
              if (clk_fall) begin
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                  state            <= I_MACK;
                  serial_data_oe_n <= 1'b1;
                end else begin
                  serial_data_oe_n <= tx_shift[7] ? 1'b1 : 1'b0;
                  tx_shift         <= {tx_shift[6:0], 1'b0};
                end
              end
            end
            I_MACK: begin
              if (clk_rise) begin
                rw <= ~filt[`PIN_DATA];
              end else if (clk_fall) begin
                if (rw) begin
                  state            <= I_TX;
                  bit_cnt          <= 3'h0;
                  serial_data_oe_n <= read_value[7] ? 1'b1 : 1'b0;
                  tx_shift         <= {read_value[6:0], 1'b0};
                  reg_addr         <= reg_addr + 7'h01;
                end else begin
                  state <= I_WAIT;
                end
              end
            end
            I_IDLE, I_WAIT: begin
              serial_data_oe_n <= 1'b1;
            end
            default: begin
              state            <= I_IDLE;
              serial_data_oe_n <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  // Mirror of local inputs toward the remote outputs, and interrupt pin
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      remote_mirror_levels <= 3'h0;
      irq                  <= 1'b0;
    end else begin
      remote_mirror_levels <= transmitter_mode_register[`MIRROR_ENABLE_BIT] ?
                              input_levels : 3'h0;
      irq                  <= irq_request;
    end
  end

endmodule

// ### rtl/serial_slave_control_port_defines.vh
// Offsets, field positions, reset values and constants of the serial control port
`ifndef SERIAL_SLAVE_CONTROL_PORT_DEFINES_VH
`define SERIAL_SLAVE_CONTROL_PORT_DEFINES_VH

`define MODE_REG_ADDR      7'h1A
`define INPUT_STATUS_ADDR  7'h75
`define MODE_REG_RESET     8'h00
`define MIRROR_ENABLE_BIT  3
`define CMD_READ_BIT       7
`define DEV_ADDR_LOW       6'h29
`define STRAP_SETTLE       3'h4
`define PIN_COUNT          7

`define PIN_SELECT         0
`define PIN_CS_OR_ADDR     1
`define PIN_CLOCK          2
`define PIN_MOSI_OR_DD2    3
`define PIN_DD1            4
`define PIN_DD0            5
`define PIN_DATA           6

`endif

// ### test/host_master.sv
// Host controller model for the SPI and 2-wire pins
module host_master (
  input  wire logic mclk,
  input  wire logic miso,
  input  wire logic sda,
  output logic      cs_n = 1'b1,
  output logic      sck = 1'b0,
  output logic      mosi = 1'b0,
  output logic      sda_drv = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic spi_sel(input logic v);
    cs_n = v;
    tick(8);
  endtask
  // Read each bit just before the fall that replaces it
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      tick(4);
      sck = 1'b1;
      tick(4);
      rx[i] = miso;
      sck = 1'b0;
    end
    mosi = ~mosi;
    tick(8);
  endtask
  // Long low phase leaves room for the slave's sampling lag
  task automatic tw_bit(input logic b, output logic r);
    sda_drv = b;
    tick(6);
    sck = 1'b1;
    tick(4);
    r = sda;
    sck = 1'b0;
  endtask
  task automatic tw_start();
    sda_drv = 1'b1;
    tick(6);
    sck = 1'b1;
    tick(4);
    sda_drv = 1'b0;
    tick(4);
    sck = 1'b0;
  endtask
  task automatic tw_stop();
    sda_drv = 1'b0;
    tick(6);
    sck = 1'b1;
    tick(4);
    sda_drv = 1'b1;
    tick(8);
  endtask
  task automatic tw_byte(input logic [7:0] tx, input logic hack, output logic [7:0] rx,
                         output logic ack);
    for (int i = 7; i >= 0; i--) tw_bit(tx[i], rx[i]);
    tw_bit(hack, ack);
  endtask
endmodule

// ### test/serial_slave_control_port_sva.sv
// Concurrent checks on the serial control port outputs
`include "serial_slave_control_port_defines.vh"
module serial_slave_control_port_sva (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       interface_select,
  input wire logic       cs_n_or_address_strap,
  input wire logic       local_input1,
  input wire logic       local_input0,
  input wire logic       serial_data_out,
  input wire logic       serial_data_oe_n,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic [7:0] transmitter_mode_register,
  input wire logic [2:0] remote_mirror_levels,
  input wire logic       irq_request,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  reset_clear_a: assert property ($rose(arst_n) |-> !reg_write && reg_addr == 7'h00)
    else $error("port state not cleared by reset");
  addr_step_a: assert property (reg_write |-> reg_addr == $past(reg_addr) + 7'h01)
    else $error("address not advanced with write");
  write_pulse_a: assert property (reg_write |=> !reg_write)
    else $error("write strobe longer than one cycle");
  mode_copy_a: assert property (reg_write && reg_addr == `MODE_REG_ADDR + 7'h01
    |-> ##[0:2] transmitter_mode_register == reg_wdata) else $error("mode copy not updated");
  mirror_off_a: assert property ((!transmitter_mode_register[3]) [*3]
    |-> remote_mirror_levels == 3'h0) else $error("mirror active while disabled");
  mirror_copy_a: assert property ((transmitter_mode_register[3]
    && $stable({local_input1, local_input0})) [*8]
    |-> remote_mirror_levels[1:0] == {local_input1, local_input0}) else $error("mirror wrong");
  irq_follow_a: assert property (irq_request ##1 irq_request |-> irq)
    else $error("irq not raised");
  irq_drop_a: assert property (!irq_request ##1 !irq_request |-> !irq)
    else $error("irq not cleared");
  spi_idle_a: assert property ((!interface_select && cs_n_or_address_strap) [*8]
    |-> serial_data_oe_n) else $error("output driven while deselected");
  open_drain_a: assert property (interface_select [*4] |-> !serial_data_out)
    else $error("data line driven high in 2-wire mode");
endmodule
bind serial_slave_control_port serial_slave_control_port_sva chk (.mclk, .arst_n,
  .interface_select, .cs_n_or_address_strap, .local_input1, .local_input0, .serial_data_out,
  .serial_data_oe_n, .reg_addr, .reg_wdata, .reg_write, .transmitter_mode_register,
  .remote_mirror_levels, .irq_request, .irq);

// ### test/serial_slave_control_port_tb.sv
// Self-checking bench of the serial control port driven by a host model
module serial_slave_control_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic       sel = 1'b0;
  logic       strap = 1'b1;
  logic       in2 = 1'b1;
  logic       in1 = 1'b0;
  logic       in0 = 1'b1;
  logic       irq_request = 1'b0;
  logic [7:0] mem [0:127];
  int         error_cnt = 0;
  int         compares = 0;
  int         cycles = 0;
  wire        cs_n, sck, mosi, sda_drv, dout, oe_n, irq, reg_write;
  wire  [6:0] reg_addr;
  wire  [7:0] reg_wdata, mode;
  wire  [2:0] mirror;
  wire        sda = sda_drv & (oe_n | dout);
  wire        scl_out, scl_oe_n;
  wire        scl = sck & (scl_oe_n | scl_out);
  serial_slave_control_port uut (.mclk(mclk), .arst_n(arst_n), .interface_select(sel),
    .cs_n_or_address_strap(sel ? strap : cs_n), .serial_clock_in(scl),
    .mosi_or_input2(sel ? in2 : mosi), .local_input1(in1), .local_input0(in0),
    .serial_data_in(sda), .serial_data_out(dout), .serial_data_oe_n(oe_n),
    .two_wire_clock_out(scl_out), .two_wire_clock_oe_n(scl_oe_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(mem[reg_addr]),
    .transmitter_mode_register(mode), .remote_mirror_levels(mirror),
    .irq_request(irq_request), .irq(irq));
  host_master m (.mclk(mclk), .miso(dout), .sda(sda), .cs_n(cs_n), .sck(sck), .mosi(mosi),
    .sda_drv(sda_drv));
  initial forever #50 mclk = ~mclk;
  // Written address trails the already advanced address by one
  always @(posedge mclk) if (reg_write) mem[reg_addr - 7'h01] <= reg_wdata;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset(input logic mode_sel);
    arst_n = 1'b0;
    sel = mode_sel;
    m.tick(12);
    arst_n = 1'b1;
    m.tick(10);
  endtask
  task automatic spi_access(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1,
                            output logic [7:0] r0, output logic [7:0] r1);
    logic [7:0] r;
    m.spi_sel(1'b0);
    m.spi_byte(cmd, r);
    m.spi_byte(d0, r0);
    m.spi_byte(d1, r1);
    m.spi_sel(1'b1);
  endtask
  task automatic spi_scenarios();
    logic [7:0] a, b;
    spi_access(8'h10, 8'hA5, 8'h3C, a, b);
    check(mem[7'h10], 8'hA5);
    check(mem[7'h11], 8'h3C);
    spi_access(8'hC0, 8'h00, 8'h00, a, b);
    check(a, 8'hC0);
    check(b, 8'hC1);
    spi_access(8'h1A, 8'h08, 8'h1B, a, b);
    check(mode, 8'h08);
    check({6'h00, mirror[1:0]}, {6'h00, in1, in0});
    spi_access(8'hF5, 8'h00, 8'h00, a, b);
    check(a, {6'h00, in1, in0});
  endtask
  task automatic tw_send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] r;
    logic       a;
    m.tw_byte(b, 1'b1, r, a);
    check({7'h00, a}, {7'h00, exp_ack});
  endtask
  task automatic tw_scenarios();
    logic [7:0] r;
    logic       a;
    m.tw_start();
    tw_send(8'hD2, 1'b0);
    tw_send(8'h1A, 1'b0);
    tw_send(8'h08, 1'b0);
    tw_send(8'h77, 1'b0);
    m.tw_stop();
    check(mode, 8'h08);
    check(mem[7'h1B], 8'h77);
    check({5'h00, mirror}, {5'h00, in2, in1, in0});
    in1 = 1'b1;
    in0 = 1'b0;
    m.tick(8);
    check({5'h00, mirror}, {5'h00, in2, in1, in0});
    m.tw_start();
    tw_send(8'h52, 1'b1);
    m.tw_stop();
    m.tw_start();
    tw_send(8'hD2, 1'b0);
    tw_send(8'h75, 1'b0);
    m.tw_start();
    tw_send(8'hD3, 1'b0);
    m.tw_byte(8'hFF, 1'b0, r, a);
    check(r, {5'h00, in2, in1, in0});
    m.tw_byte(8'hFF, 1'b1, r, a);
    check(r, 8'hF6);
    m.tw_stop();
  endtask
  // Strap low moves the bus address to the lower half
  task automatic tw_strap_low();
    strap = 1'b0;
    do_reset(1'b1);
    m.tw_start();
    tw_send(8'hD2, 1'b1);
    m.tw_stop();
    m.tw_start();
    tw_send(8'h52, 1'b0);
    tw_send(8'h1A, 1'b0);
    tw_send(8'h5A, 1'b0);
    m.tw_stop();
    check(mode, 8'h5A);
    in2 = 1'b0;
    m.tick(8);
    check({5'h00, mirror}, {5'h00, in2, in1, in0});
  endtask
  task automatic irq_pass();
    irq_request = 1'b1;
    m.tick(3);
    check({7'h00, irq}, 8'h01);
    irq_request = 1'b0;
    m.tick(3);
    check({7'h00, irq}, 8'h00);
  endtask
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'h80 | 8'(i);
    do_reset(1'b0);
    spi_scenarios();
    irq_pass();
    do_reset(1'b1);
    tw_scenarios();
    irq_pass();
    tw_strap_low();
    give_verdict();
  end
endmodule
